/* File: hdl/ldp_pkg.sv */
// shared constants and carriers for the led driver register port
package ldp_pkg;

    // bus address: fixed upper five bits, low two from the strap
    localparam logic [4:0] ADDR_PATTERN   = 5'h1D;  // binary 11101
    localparam logic [1:0] STRAP_GND      = 2'h0;   // strap tied low
    localparam logic [1:0] STRAP_VCC      = 2'h3;   // strap tied high
    localparam logic [1:0] STRAP_SCL      = 2'h1;   // strap tied to clock line
    localparam logic [1:0] STRAP_SDA      = 2'h2;   // strap tied to data line

    // register offsets
    localparam logic [7:0] REG_CONFIG     = 8'h00;
    localparam logic [7:0] REG_ONOFF_UP   = 8'h01;
    localparam logic [7:0] REG_ONOFF_LO   = 8'h02;
    localparam logic [7:0] REG_EFFECT     = 8'h03;
    localparam logic [7:0] REG_CH_ROLE    = 8'h04;
    localparam logic [7:0] REG_PORT_DIR   = 8'h05;
    localparam logic [7:0] REG_PORT_OUT   = 8'h06;
    localparam logic [7:0] REG_PORT_IRQ   = 8'h07;
    localparam logic [7:0] REG_PORT_STATE = 8'h08;
    localparam logic [7:0] REG_SAMPLER    = 8'h09;
    localparam logic [7:0] REG_DUTY_LO    = 8'h10;
    localparam logic [7:0] REG_DUTY_HI    = 8'h1F;
    localparam logic [7:0] REG_FRAME_LO   = 8'h20;
    localparam logic [7:0] REG_FRAME_HI   = 8'hAF;
    localparam logic [7:0] REG_DUTY_LOAD  = 8'hB0;
    localparam logic [7:0] REG_FRM_DELAY  = 8'hB6;
    localparam logic [7:0] REG_FRM_START  = 8'hB7;

    // values after reset and fixed answers
    localparam logic [7:0] RST_ONOFF      = 8'hFF;  // every channel on
    localparam logic [7:0] LOAD_CODE      = 8'h00;  // byte that commits duty values
    localparam logic [7:0] READ_FILL      = 8'hFF;  // answer for non-readable offsets
    localparam logic [1:0] MODE_RESERVED  = 2'h3;   // operating mode not available
    localparam logic [3:0] BITS_PER_BYTE  = 4'h8;

    // one-hot bus states
    typedef enum logic [7:0] {
        LDP_IDLE   = 8'h01,
        LDP_ADDR   = 8'h02,
        LDP_REG    = 8'h04,
        LDP_WDATA  = 8'h08,
        LDP_ACK    = 8'h10,
        LDP_RDATA  = 8'h20,
        LDP_MACK   = 8'h40,
        LDP_IGNORE = 8'h80
    } ldp_bus_state_t;

    // configuration seen by the led engine
    typedef struct packed {
        logic        soft_power_down;
        logic [1:0]  operating_mode;
        logic        audio_current_modulation;
        logic [15:0] led_on_off;               // [15:8] upper eight channels
        logic        cascade_role;
        logic [2:0]  current_scale;
        logic        gain_control_disable;
        logic [2:0]  audio_gain_select;
        logic [7:0]  channel_role_select;
        logic [7:0]  port_direction;
        logic [7:0]  port_output_level;
        logic [7:0]  port_interrupt_control;
        logic [7:0]  sampler_rate;
        logic [2:0]  frame_delay;
        logic [2:0]  frame_start;
    } ldp_cfg_t;

    // write strobe toward external frame storage
    typedef struct packed {
        logic        en;
        logic [7:0]  addr;
        logic [7:0]  data;
    } ldp_frame_wr_t;

    // complete state of the register port
    typedef struct packed {
        logic           scl_m;
        logic           scl_s;
        logic           scl_p;
        logic           sda_m;
        logic           sda_s;
        logic           sda_p;
        logic           ad_m;
        logic           ad_s;
        ldp_bus_state_t st;
        ldp_bus_state_t ack_next;
        logic [3:0]     bit_cnt;
        logic [7:0]     shift;
        logic [7:0]     ptr;
        logic           seen_hi;
        logic           seen_lo;
        logic           ne_scl;
        logic           ne_sda;
        logic           sda_oe_n;
        logic           load_pulse;
        ldp_cfg_t       cfg;
        logic [15:0][7:0] duty_shadow;
        logic [15:0][7:0] duty_live;
        ldp_frame_wr_t  frame_wr;
    } ldp_state_t;

endpackage

/* File: hdl/ldp_i2c_regs.sv */
// Notes on behaviour
// - answer only address 11101 plus strap bits
// - last address bit: zero write, one read
// - strap gnd 00, vcc 11, scl 01, sda 10
// - start is data falling with clock high
// - stop is data rising, return to idle
// - bytes msb first, sampled while clock high
// - hold data low during ack after match
// - first write byte loads register pointer, acked
// - data bytes stored at pointer and acknowledged
// - pointer advances by one per data ack
// - read: pointer write, restart, then data returned
// - decode control, duty, frame, load, delay, start
// - only input state at 08h reads back
// - config d7 power-down, reset value 80h
// - config d6:d5 mode, code 11 refused
// - config d4 selects audio current modulation
// - on/off bits at 01h, 02h, reset ffh
// - effect register fields at 03h, reset zero
// - duty values take effect on load zero
`timescale 1ns/1ps
`default_nettype none

module ldp_i2c_regs (
    input  wire logic               core_clk,          // 200 MHz system clock
    input  wire logic               reset,             // asynchronous, active high
    input  wire logic               clk_en,            // freezes all state when low
    input  wire logic               scl_in,            // bus clock pin level
    input  wire logic               sda_in,            // bus data pin level
    output logic                    sda_out,           // data pin drive value, always low
    output logic                    sda_oe_n,          // low while pulling data low
    input  wire logic               ad_in,             // address strap pin level
    input  wire logic [7:0]         port_input_state,  // input levels of upper channels
    output ldp_pkg::ldp_cfg_t       cfg,               // configuration fields
    output logic [15:0][7:0]        channel_duty,      // committed duty per channel
    output logic                    duty_loaded,       // pulse when duty is committed
    output ldp_pkg::ldp_frame_wr_t  frame_wr           // frame storage write strobe
);

    ldp_pkg::ldp_state_t q;          // registered state
    ldp_pkg::ldp_state_t d;          // next state
    logic                scl_rise;   // bus clock rising edge seen
    logic                scl_fall;   // bus clock falling edge seen
    logic                start_c;    // start condition seen
    logic                stop_c;     // stop condition seen
    logic [1:0]          strap;      // decoded low address bits
    logic                addr_hit;   // received address is ours
    logic [7:0]          rd_byte;    // byte returned on a read

    // outputs other than sda_out come straight from the state flops, sda_out is tied low
    assign sda_out      = 1'b0;
    assign sda_oe_n     = q.sda_oe_n;
    assign cfg          = q.cfg;
    assign channel_duty = q.duty_live;
    assign duty_loaded  = q.load_pulse;
    assign frame_wr     = q.frame_wr;

    // edge and condition detect on synchronised pins
    always_comb begin
        scl_rise = q.scl_s & ~q.scl_p;
        scl_fall = ~q.scl_s & q.scl_p;
        // both samples high on the clock line so a clock edge is not mistaken
        start_c  = q.scl_s & q.scl_p & q.sda_p & ~q.sda_s;
        stop_c   = q.scl_s & q.scl_p & ~q.sda_p & q.sda_s;
    end

    // strap decode: what the strap pin did while the address came in
    always_comb begin
        if (!q.seen_hi) begin
            strap = ldp_pkg::STRAP_GND;
        end else if (!q.seen_lo) begin
            strap = ldp_pkg::STRAP_VCC;
        end else if (!q.ne_scl) begin
            strap = ldp_pkg::STRAP_SCL;
        end else begin
            strap = ldp_pkg::STRAP_SDA;
        end
        addr_hit = (q.shift[7:1] == {ldp_pkg::ADDR_PATTERN, strap});
    end

    // read answer: only the input state register gives real data
    always_comb begin
        if (q.ptr == ldp_pkg::REG_PORT_STATE) begin
            rd_byte = port_input_state;
        end else begin
            rd_byte = ldp_pkg::READ_FILL;
        end
    end

    // next-state logic for the whole port
    always_comb begin
        d = q;

        // two-flop synchronisers, third flop for edge history
        d.scl_m = scl_in;
        d.scl_s = q.scl_m;
        d.scl_p = q.scl_s;
        d.sda_m = sda_in;
        d.sda_s = q.sda_m;
        d.sda_p = q.sda_s;
        d.ad_m  = ad_in;
        d.ad_s  = q.ad_m;

        // strobes last one cycle
        d.frame_wr.en = 1'b0;
        d.load_pulse  = 1'b0;

        // strap observation while the address byte is on the bus
        if (q.st == ldp_pkg::LDP_ADDR) begin
            d.seen_hi = q.seen_hi | q.ad_s;
            d.seen_lo = q.seen_lo | ~q.ad_s;
            d.ne_scl  = q.ne_scl | (q.ad_s ^ q.scl_s);
            d.ne_sda  = q.ne_sda | (q.ad_s ^ q.sda_s);
        end

        if (start_c) begin
            // start or repeated start: begin a fresh address byte
            d.st       = ldp_pkg::LDP_ADDR;
            d.bit_cnt  = 4'h0;
            d.sda_oe_n = 1'b1;
            d.seen_hi  = 1'b0;
            d.seen_lo  = 1'b0;
            d.ne_scl   = 1'b0;
            d.ne_sda   = 1'b0;
        end else if (stop_c) begin
            // stop ends any transfer and frees the data line
            d.st       = ldp_pkg::LDP_IDLE;
            d.sda_oe_n = 1'b1;
        end else begin
            case (q.st)
                ldp_pkg::LDP_ADDR,
                ldp_pkg::LDP_REG,
                ldp_pkg::LDP_WDATA: begin
                    if (scl_rise) begin
                        // sample on the high phase, msb first
                        d.shift   = {q.shift[6:0], q.sda_s};
                        d.bit_cnt = q.bit_cnt + 4'h1;
                    end else if (scl_fall && q.bit_cnt == ldp_pkg::BITS_PER_BYTE) begin
                        d.bit_cnt = 4'h0;
                        if (q.st == ldp_pkg::LDP_ADDR) begin
                            if (addr_hit) begin
                                // pull data low for the ack pulse
                                d.sda_oe_n = 1'b0;
                                d.st       = ldp_pkg::LDP_ACK;
                                if (q.shift[0]) begin
                                    d.ack_next = ldp_pkg::LDP_RDATA;
                                end else begin
                                    d.ack_next = ldp_pkg::LDP_REG;
                                end
                            end else begin
                                // not ours: stay off the bus until a start
                                d.st = ldp_pkg::LDP_IGNORE;
                            end
                        end else if (q.st == ldp_pkg::LDP_REG) begin
                            // first byte of a write is the register pointer
                            d.ptr      = q.shift;
                            d.sda_oe_n = 1'b0;
                            d.st       = ldp_pkg::LDP_ACK;
                            d.ack_next = ldp_pkg::LDP_WDATA;
                        end else begin
                            // data byte: store, ack, advance pointer
                            d.sda_oe_n = 1'b0;
                            d.st       = ldp_pkg::LDP_ACK;
                            d.ack_next = ldp_pkg::LDP_WDATA;
                            d.ptr      = q.ptr + 8'h01;
                            // register decode by offset
                            if (q.ptr == ldp_pkg::REG_CONFIG) begin
                                d.cfg.soft_power_down = q.shift[7];
                                if (q.shift[6:5] != ldp_pkg::MODE_RESERVED) begin
                                    d.cfg.operating_mode = q.shift[6:5];
                                end
                                d.cfg.audio_current_modulation = q.shift[4];
                            end else if (q.ptr == ldp_pkg::REG_ONOFF_UP) begin
                                d.cfg.led_on_off[15:8] = q.shift;
                            end else if (q.ptr == ldp_pkg::REG_ONOFF_LO) begin
                                d.cfg.led_on_off[7:0] = q.shift;
                            end else if (q.ptr == ldp_pkg::REG_EFFECT) begin
                                d.cfg.cascade_role         = q.shift[7];
                                d.cfg.current_scale        = q.shift[6:4];
                                d.cfg.gain_control_disable = q.shift[3];
                                d.cfg.audio_gain_select    = q.shift[2:0];
                            end else if (q.ptr == ldp_pkg::REG_CH_ROLE) begin
                                d.cfg.channel_role_select = q.shift;
                            end else if (q.ptr == ldp_pkg::REG_PORT_DIR) begin
                                d.cfg.port_direction = q.shift;
                            end else if (q.ptr == ldp_pkg::REG_PORT_OUT) begin
                                d.cfg.port_output_level = q.shift;
                            end else if (q.ptr == ldp_pkg::REG_PORT_IRQ) begin
                                d.cfg.port_interrupt_control = q.shift;
                            end else if (q.ptr == ldp_pkg::REG_SAMPLER) begin
                                d.cfg.sampler_rate = q.shift;
                            end else if (q.ptr >= ldp_pkg::REG_DUTY_LO &&
                                         q.ptr <= ldp_pkg::REG_DUTY_HI) begin
                                // held in shadow until zero is written to the load register
                                d.duty_shadow[q.ptr[3:0]] = q.shift;
                            end else if (q.ptr >= ldp_pkg::REG_FRAME_LO &&
                                         q.ptr <= ldp_pkg::REG_FRAME_HI) begin
                                d.frame_wr.en   = 1'b1;
                                d.frame_wr.addr = q.ptr;
                                d.frame_wr.data = q.shift;
                            end else if (q.ptr == ldp_pkg::REG_DUTY_LOAD) begin
                                if (q.shift == ldp_pkg::LOAD_CODE) begin
                                    d.duty_live  = q.duty_shadow;
                                    d.load_pulse = 1'b1;
                                end
                            end else if (q.ptr == ldp_pkg::REG_FRM_DELAY) begin
                                d.cfg.frame_delay = q.shift[7:5];
                            end else if (q.ptr == ldp_pkg::REG_FRM_START) begin
                                d.cfg.frame_start = q.shift[7:5];
                            end else begin
                                // unmapped or read-only: acked, nothing stored
                                d.frame_wr.en = 1'b0;
                            end
                        end
                    end
                end
                ldp_pkg::LDP_ACK: begin
                    // ack pulse ends on the falling clock
                    if (scl_fall) begin
                        d.sda_oe_n = 1'b1;
                        d.st       = q.ack_next;
                        d.bit_cnt  = 4'h0;
                        if (q.ack_next == ldp_pkg::LDP_RDATA) begin
                            // present first bit of the read byte
                            d.shift    = rd_byte;
                            d.sda_oe_n = rd_byte[7];
                        end
                    end
                end
                ldp_pkg::LDP_RDATA: begin
                    // shift read data out on each falling clock, msb first
                    if (scl_fall) begin
                        d.bit_cnt = q.bit_cnt + 4'h1;
                        if (q.bit_cnt + 4'h1 == ldp_pkg::BITS_PER_BYTE) begin
                            d.sda_oe_n = 1'b1;                // release for the controller ack
                            d.st       = ldp_pkg::LDP_MACK;
                        end else begin
                            d.shift    = {q.shift[6:0], 1'b1};
                            d.sda_oe_n = q.shift[6];
                        end
                    end
                end
                ldp_pkg::LDP_MACK: begin
                    // controller answers the read byte
                    if (scl_rise) begin
                        if (q.sda_s) begin
                            // no ack: controller is done, wait for stop
                            d.st = ldp_pkg::LDP_IGNORE;
                        end else begin
                            // ack: next byte follows from the next offset
                            d.st       = ldp_pkg::LDP_ACK;
                            d.ack_next = ldp_pkg::LDP_RDATA;
                            d.ptr      = q.ptr + 8'h01;
                        end
                    end
                end
                ldp_pkg::LDP_IDLE,
                ldp_pkg::LDP_IGNORE: begin
                    // line released, wait for a start
                    d.sda_oe_n = 1'b1;
                end
                default: begin
                    // illegal code: recover to idle
                    d.st       = ldp_pkg::LDP_IDLE;
                    d.sda_oe_n = 1'b1;
                end
            endcase
        end
    end

    // state register with clock enable
    always_ff @(posedge core_clk or posedge reset) begin
        if (reset) begin
            q                      <= '0;
            q.scl_m                <= 1'b1;
            q.scl_s                <= 1'b1;
            q.scl_p                <= 1'b1;
            q.sda_m                <= 1'b1;
            q.sda_s                <= 1'b1;
            q.sda_p                <= 1'b1;
            q.st                   <= ldp_pkg::LDP_IDLE;
            q.ack_next             <= ldp_pkg::LDP_IDLE;
            q.sda_oe_n             <= 1'b1;
            q.cfg.soft_power_down  <= 1'b1;
            q.cfg.led_on_off       <= {ldp_pkg::RST_ONOFF, ldp_pkg::RST_ONOFF};
        end else if (clk_en) begin
            q <= d;
        end
    end

endmodule

`default_nettype wire

/* File: testbench/ldp_i2c_regs_monitor.sv */
`timescale 1ns/1ps
`default_nettype none
// pin-level checks on the register port
module ldp_i2c_regs_monitor (
    input wire logic                   core_clk,
    input wire logic                   reset,
    input wire logic                   scl_in,
    input wire logic                   sda_oe_n,
    input wire ldp_pkg::ldp_cfg_t      cfg,
    input wire logic [15:0][7:0]       channel_duty,
    input wire logic                   duty_loaded,
    input wire ldp_pkg::ldp_frame_wr_t frame_wr
);
    default clocking cb @(posedge core_clk); endclocking
    default disable iff (reset);
    a_reset_vals: assert property ($fell(reset) |-> sda_oe_n && cfg.soft_power_down
        && cfg.led_on_off == 16'hFFFF && cfg.current_scale == 3'h0) else $error("reset values");
    a_mode_legal: assert property (cfg.operating_mode != ldp_pkg::MODE_RESERVED)
        else $error("reserved mode stored");
    a_load_pulse: assert property (duty_loaded |=> !duty_loaded)
        else $error("load pulse too long");
    a_duty_cause: assert property ($changed(channel_duty) |-> duty_loaded
        || $past(duty_loaded)) else $error("duty changed without load");
    a_frame_range: assert property (frame_wr.en |-> frame_wr.addr >= 8'h20
        && frame_wr.addr <= 8'hAF ##1 !frame_wr.en) else $error("frame strobe wrong");
    a_oe_low_phase: assert property ($changed(sda_oe_n) |-> !scl_in)
        else $error("data line moved while clock high");
    a_ack_hold: assert property ($fell(sda_oe_n) |-> !sda_oe_n [*8])
        else $error("data low too short");
    a_cfg_low_phase: assert property ($changed(cfg) |-> !scl_in)
        else $error("configuration moved while clock high");
    // main scenarios reached
    c_ack: cover property ($fell(sda_oe_n));
    c_load: cover property (duty_loaded);
    c_frame: cover property (frame_wr.en);
endmodule
bind ldp_i2c_regs ldp_i2c_regs_monitor MON (.core_clk(core_clk), .reset(reset),
    .scl_in(scl_in), .sda_oe_n(sda_oe_n), .cfg(cfg), .channel_duty(channel_duty),
    .duty_loaded(duty_loaded), .frame_wr(frame_wr));
`default_nettype wire

/* File: testbench/ldp_host_model.sv */
`timescale 1ns/1ps
`default_nettype none
// bus controller: clock stands high between frames, data high means released
module ldp_host_model (
    output logic     scl_o,  // bus clock, 48 ns period inside frames
    output logic     sda_o,  // low pulls the line down
    input wire logic sda_w   // resolved data line
);
    initial begin
        scl_o = 1'b1;
        sda_o = 1'b1;
    end
    // data set in the low phase, held through the high phase
    task automatic bit_out(input logic b);
        sda_o = b;
        #12 scl_o = 1'b1;
        #24 scl_o = 1'b0;
        #12;
    endtask
    // release the line, sample in mid high phase
    task automatic bit_in(output logic b);
        sda_o = 1'b1;
        #12 scl_o = 1'b1;
        #12 b = sda_w;
        #12 scl_o = 1'b0;
        #12;
    endtask
    // start and repeated start: data falls with clock high
    task automatic start();
        sda_o = 1'b1;
        #12 scl_o = 1'b1;
        #24 sda_o = 1'b0;
        #24 scl_o = 1'b0;
        #12;
    endtask
    // stop: data rises with clock high
    task automatic stop();
        sda_o = 1'b0;
        #12 scl_o = 1'b1;
        #24 sda_o = 1'b1;
        #48;
    endtask
    task automatic send_byte(input logic [7:0] d, output logic ack);
        logic b;
        for (int i = 7; i >= 0; i--) bit_out(d[i]);
        bit_in(b);
        ack = ~b;
    endtask
    task automatic recv_byte(output logic [7:0] d, input logic ack_m);
        for (int i = 7; i >= 0; i--) bit_in(d[i]);
        bit_out(~ack_m);
    endtask
endmodule
`default_nettype wire

/* File: testbench/tb_ldp_i2c_regs.sv */
`timescale 1ns/1ps
`default_nettype none
module tb_ldp_i2c_regs;
    logic                  core_clk = 1'b0;
    logic                  reset    = 1'b1;
    logic                  sda_oe_n, sda_out, scl_w, host_sda, duty_loaded;
    logic [1:0]            ad_sel   = ldp_pkg::STRAP_GND;  // strap wiring choice
    logic [7:0]            pis      = 8'h00;              // port input levels
    logic [7:0]            rd, rd2;
    ldp_pkg::ldp_cfg_t     cfg;
    // configuration fields gathered for compact compares
    wire [3:0] cfg_mode = {cfg.soft_power_down, cfg.operating_mode, cfg.audio_current_modulation};
    wire [7:0] cfg_fx   = {cfg.cascade_role, cfg.current_scale, cfg.gain_control_disable,
                           cfg.audio_gain_select};
    logic [15:0][7:0]      duty;
    ldp_pkg::ldp_frame_wr_t fwr, fr_seen;
    int                    ld_cnt = 0, err_total = 0, num_checks = 0;
    // open-drain line with pull-up, strap follows its wiring
    wire sda_w = host_sda & (sda_oe_n | sda_out);
    wire ad_w  = (ad_sel == ldp_pkg::STRAP_GND) ? 1'b0 : (ad_sel == ldp_pkg::STRAP_VCC) ? 1'b1 :
                 (ad_sel == ldp_pkg::STRAP_SCL) ? scl_w : sda_w;
    ldp_i2c_regs DUT (.core_clk(core_clk), .reset(reset), .clk_en(1'b1), .scl_in(scl_w),
        .sda_in(sda_w), .sda_out(sda_out), .sda_oe_n(sda_oe_n), .ad_in(ad_w),
        .port_input_state(pis), .cfg(cfg), .channel_duty(duty), .duty_loaded(duty_loaded),
        .frame_wr(fwr));
    ldp_host_model HOST (.scl_o(scl_w), .sda_o(host_sda), .sda_w(sda_w));
    initial forever #2.5 core_clk = ~core_clk;
    // catch one-cycle strobes
    always @(posedge core_clk) begin
        if (fwr.en === 1'b1) fr_seen <= fwr;
        if (duty_loaded === 1'b1) ld_cnt <= ld_cnt + 1;
    end
    task automatic chk(input string nm, input logic [15:0] exp, input logic [15:0] got);
        num_checks++;
        if (got !== exp) begin
            err_total++;
            $display("ERROR %s expected %h seen %h", nm, exp, got);
        end
    endtask
    task automatic put(input logic [7:0] d, input logic exp_ack);
        logic a;
        HOST.send_byte(d, a);
        chk("ack", {15'h0, exp_ack}, {15'h0, a});
    endtask
    task automatic open_wr(input logic [7:0] p);
        HOST.start();
        put({ldp_pkg::ADDR_PATTERN, ad_sel, 1'b0}, 1'b1);
        put(p, 1'b1);
    endtask
    task automatic t_strap();
        for (int i = 0; i < 4; i++) begin
            @(posedge core_clk) ad_sel <= i[1:0];
            open_wr(ldp_pkg::REG_SAMPLER);
            put(8'h10 + 8'(i), 1'b1);
            HOST.stop();
            chk("sampler", 16'h10 + 16'(i), {8'h0, cfg.sampler_rate});
        end
        @(posedge core_clk) ad_sel <= ldp_pkg::STRAP_GND;
        HOST.start();
        put({ldp_pkg::ADDR_PATTERN, ldp_pkg::STRAP_VCC, 1'b0}, 1'b0);
        put(8'h55, 1'b0);
        HOST.stop();
        chk("sampler kept", 16'h13, {8'h0, cfg.sampler_rate});
        $display("test strap done");
    endtask
    task automatic t_burst();
        open_wr(ldp_pkg::REG_CONFIG);
        put(8'h30, 1'b1);
        put(8'h5A, 1'b1);
        put(8'hA5, 1'b1);
        put(8'hB5, 1'b1);
        HOST.stop();
        chk("config", 16'h3, {12'h0, cfg_mode});
        chk("on_off", 16'h5AA5, cfg.led_on_off);
        chk("effect", 16'hB5, {8'h0, cfg_fx});
        open_wr(ldp_pkg::REG_CONFIG);
        put(8'hE0, 1'b1);
        HOST.stop();
        chk("config mode 11", 16'hA, {12'h0, cfg_mode});
        // port control block 04h..07h, then a dropped write to the read-only offset
        open_wr(ldp_pkg::REG_CH_ROLE);
        put(8'h11, 1'b1);
        put(8'h22, 1'b1);
        put(8'h33, 1'b1);
        put(8'h44, 1'b1);
        put(8'h99, 1'b1);
        HOST.stop();
        chk("port regs", 16'h1122, {cfg.channel_role_select, cfg.port_direction});
        chk("port regs2", 16'h3344, {cfg.port_output_level, cfg.port_interrupt_control});
        // frame timing fields live in the top three bits
        open_wr(ldp_pkg::REG_FRM_DELAY);
        put(8'hE0, 1'b1);
        put(8'hA0, 1'b1);
        HOST.stop();
        chk("frame timing", 16'h3D, {10'h0, cfg.frame_delay, cfg.frame_start});
        $display("test burst done");
    endtask
    task automatic t_duty();
        open_wr(8'h1F);
        put(8'h3C, 1'b1);
        put(8'h77, 1'b1);
        HOST.stop();
        chk("duty shadowed", 16'h0, {8'h0, duty[15]});
        chk("frame strobe", 16'h2077, {fr_seen.addr, fr_seen.data});
        for (int v = 1; v >= 0; v--) begin
            open_wr(ldp_pkg::REG_DUTY_LOAD);
            put(8'(v), 1'b1);
            HOST.stop();
            chk("duty", (v == 1) ? 16'h0 : 16'h3C, {8'h0, duty[15]});
        end
        chk("loads", 16'h1, 16'(ld_cnt));
        $display("test duty done");
    endtask
    task automatic t_read();
        @(posedge core_clk) pis <= 8'hC3;
        open_wr(ldp_pkg::REG_PORT_STATE);
        HOST.start();
        put({ldp_pkg::ADDR_PATTERN, ad_sel, 1'b1}, 1'b1);
        HOST.recv_byte(rd, 1'b1);
        HOST.recv_byte(rd2, 1'b0);
        HOST.stop();
        chk("state read", 16'hC3, {8'h0, rd});
        chk("write-only read", 16'hFF, {8'h0, rd2});
        chk("sampler intact", 16'h13, {8'h0, cfg.sampler_rate});
        $display("test read done");
    endtask
    task automatic close_out();
        $display("checks %0d mismatches %0d", num_checks, err_total);
        if (err_total == 0 && num_checks > 0) begin
            $display("Regression OK");
        end else begin
            $display("Regression broken");
        end
        $finish;
    endtask
    // main sequence: reset, let synchronisers fill, then the scenarios
    initial begin
        repeat (3) @(posedge core_clk);
        reset <= 1'b0;
        repeat (4) @(posedge core_clk);
        chk("reset config", 16'h8, {12'h0, cfg_mode});
        chk("reset on_off", 16'hFFFF, cfg.led_on_off);
        chk("reset effect", 16'h0, {8'h0, cfg_fx});
        chk("drive level", 16'h0, {15'h0, sda_out});
        t_strap();
        t_burst();
        t_duty();
        t_read();
        close_out();
    end
    // watchdog well beyond the roughly 23 us of traffic
    initial begin
        #200000;
        err_total++;
        close_out();
    end
endmodule
`default_nettype wire
